//--- logic/dbl_vlan_key_fields.sv
// Upper field builder of the double VLAN quad key, with a small register port.
// Assumes the frame parser and the matcher share the core clock; frames arrive one per cycle
// at most and the lower key fields are merged by the logic that consumes the key.
`timescale 1ns/100ps

module dbl_vlan_key_fields (
  input wire logic core_clk,
  input wire logic rst_b,
  input dvk_pkg::frame_desc_t frame_in,
  input dvk_pkg::reg_req_t reg_req,
  output dvk_pkg::key_out_t key_out,
  output logic half_key_type,
  output logic [31:0] rd_data
);
  import dvk_pkg::*;

  dec_t dec;
  logic [CTRL_W-1:0] ctrl_r;
  logic [CNT_W-1:0] frame_cnt_r;
  logic [CNT_W-1:0] oam_cnt_r;
  logic [CNT_W-1:0] frag_cnt_r;
  logic [KEY_W-1:0] key_nxt;
  logic [31:0] rd_nxt;
  logic key_valid_r;
  logic [KEY_W-1:0] key_r;
  logic half_key_type_r;
  logic [31:0] rd_data_r;

  frame_field_decoder u_decoder (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .frame(frame_in),
    .en(ctrl_r[CTRL_EN_BIT]),
    .dec_r(dec)
  );

  // Control register: enable, half key type and automatic type choice.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= CTRL_RESET;
    end else if (reg_req.wr && reg_req.addr == REG_CTRL) begin
      ctrl_r <= reg_req.wdata[CTRL_W-1:0];
    end
  end

  // Bits below the type flag other than the OAM flag belong to other builders and stay zero,
  // so the consumer can OR its own fields into the vector without masking.
  always_comb begin
    key_nxt = '0;
    key_nxt[KEY_OAM_POS] = dec.oam;
    key_nxt[KEY_TYPE_FLAG_POS] = dec.type_flag;
    key_nxt[KEY_OVL_POS +: OVL_W] = dec.ovl;
    key_nxt[KEY_IP_OR_SNAP_FLAG_POS] = dec.ip_or_snap_flag;
    key_nxt[KEY_IPV4_POS] = dec.ipv4;
    key_nxt[KEY_FRAG_POS] = dec.frag;
    key_nxt[KEY_NONFIRST_POS] = dec.nonfirst;
    key_nxt[KEY_OPTS_POS] = dec.opts;
    key_nxt[KEY_DSCP_POS +: DSCP_W] = dec.dscp;
    key_nxt[KEY_TCP_OR_UDP_FLAG_POS] = dec.tcp_or_udp_flag;
    key_nxt[KEY_TCP_POS] = dec.tcp;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      key_valid_r <= 1'h0;
    end else begin
      key_valid_r <= dec.valid;
    end
  end

  // The key holds its value between frames so that the last one stays readable.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      key_r <= '0;
    end else if (dec.valid) begin
      key_r <= key_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      half_key_type_r <= 1'h0;
    end else if (!ctrl_r[CTRL_AUTO_BIT]) begin
      half_key_type_r <= ctrl_r[CTRL_HALF_BIT];
    end else if (dec.valid) begin
      half_key_type_r <= dec.ipv4;
    end
  end

  // Counters wrap; a write of any value to a count register clears it, but a frame
  // counted in the same cycle wins so that no event is lost.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_cnt_r <= CNT_RESET;
    end else if (dec.valid) begin
      frame_cnt_r <= (reg_req.wr && reg_req.addr == REG_COUNT) ? 16'h0001 : frame_cnt_r + 16'h0001;
    end else if (reg_req.wr && reg_req.addr == REG_COUNT) begin
      frame_cnt_r <= CNT_RESET;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      oam_cnt_r <= CNT_RESET;
    end else if (dec.valid && dec.oam) begin
      oam_cnt_r <= (reg_req.wr && reg_req.addr == REG_COUNT) ? 16'h0001 : oam_cnt_r + 16'h0001;
    end else if (reg_req.wr && reg_req.addr == REG_COUNT) begin
      oam_cnt_r <= CNT_RESET;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      frag_cnt_r <= CNT_RESET;
    end else if (dec.valid && (dec.frag || dec.opts)) begin
      frag_cnt_r <= (reg_req.wr && reg_req.addr == REG_FRAG_COUNT) ? 16'h0001
                    : frag_cnt_r + 16'h0001;
    end else if (reg_req.wr && reg_req.addr == REG_FRAG_COUNT) begin
      frag_cnt_r <= CNT_RESET;
    end
  end

  always_comb begin
    case (reg_req.addr)
      REG_CTRL: rd_nxt = {29'h0000_0000, ctrl_r};
      REG_COUNT: rd_nxt = {oam_cnt_r, frame_cnt_r};
      REG_LAST_KEY: rd_nxt = {2'h0, key_r[KEY_W-1:KEY_TYPE_FLAG_POS]};
      REG_FRAG_COUNT: rd_nxt = {16'h0000, frag_cnt_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Read data stand for exactly the cycle after the strobe and are zero otherwise.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_r <= 32'h0000_0000;
    end else if (reg_req.rd) begin
      rd_data_r <= rd_nxt;
    end else begin
      rd_data_r <= 32'h0000_0000;
    end
  end

  assign key_out.valid = key_valid_r;
  assign key_out.key = key_r;
  assign half_key_type = half_key_type_r;
  assign rd_data = rd_data_r;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  logic [OVL_W-1:0] ovl_seen;
  assign ovl_seen = key_r[KEY_OVL_POS +: OVL_W];

  property p_type_flag;
    key_valid_r |-> key_r[KEY_TYPE_FLAG_POS] == ($past(frame_in.type_or_length_flag, 2) >= TYPE_MIN);
  endproperty
  a_type_flag: assert property (p_type_flag)
    else $error("type or length flag wrong");

  property p_llc_snap;
    key_valid_r && !key_r[KEY_TYPE_FLAG_POS] |-> ovl_seen == ($past(frame_in.is_snap, 2)
      ? $past(frame_in.pid_hi, 2) : {$past(frame_in.dsap, 2), $past(frame_in.ssap, 2)});
  endproperty
  a_llc_snap: assert property (p_llc_snap)
    else $error("LLC or SNAP overload wrong");

  property p_l4_port;
    key_valid_r && key_r[KEY_TCP_OR_UDP_FLAG_POS] && !key_r[KEY_OAM_POS]
      |-> ovl_seen == $past(frame_in.dport, 2);
  endproperty
  a_l4_port: assert property (p_l4_port)
    else $error("destination port not in overloaded field");

  property p_oam_field;
    key_valid_r && key_r[KEY_OAM_POS] |-> ovl_seen[15:8] == OAM_HI
      && ovl_seen[7] == $past(frame_in.oam_masq, 2)
      && ovl_seen[6:0] == $past(frame_in.meg_level, 2);
  endproperty
  a_oam_field: assert property (p_oam_field)
    else $error("OAM overload encoding wrong");

  property p_oam_flag;
    key_valid_r |-> key_r[KEY_OAM_POS] == ($past(frame_in.type_or_length_flag, 2) == OAM_OVERLOADED_TYPE_FIELD);
  endproperty
  a_oam_flag: assert property (p_oam_flag)
    else $error("OAM flag does not follow EtherType");

  property p_ip_or_snap_flag;
    key_valid_r |-> key_r[KEY_IP_OR_SNAP_FLAG_POS] == ($past(frame_in.is_ipv4, 2)
      | $past(frame_in.is_ipv6, 2) | $past(frame_in.is_snap, 2));
  endproperty
  a_ip_or_snap_flag: assert property (p_ip_or_snap_flag)
    else $error("IP or SNAP flag wrong");

  property p_frag;
    key_valid_r |-> key_r[KEY_FRAG_POS] == ($past(frame_in.is_ipv4, 2)
      && ($past(frame_in.more_frag, 2) || $past(frame_in.frag_ofs, 2) != 13'h0000));
  endproperty
  a_frag: assert property (p_frag)
    else $error("fragmented flag wrong");

  property p_nonfirst;
    key_valid_r && key_r[KEY_NONFIRST_POS] |-> key_r[KEY_FRAG_POS] && key_r[KEY_IPV4_POS];
  endproperty
  a_nonfirst: assert property (p_nonfirst)
    else $error("non-first fragment without fragment flag");

  property p_opts;
    key_valid_r |-> key_r[KEY_OPTS_POS] == ($past(frame_in.is_ipv4, 2)
      && $past(frame_in.ihl, 2) > IHL_NO_OPTS);
  endproperty
  a_opts: assert property (p_opts)
    else $error("options flag wrong");

  property p_dscp;
    key_valid_r |-> key_r[KEY_DSCP_POS +: DSCP_W] == $past(frame_in.dscp, 2);
  endproperty
  a_dscp: assert property (p_dscp)
    else $error("DSCP field wrong");

  property p_tcp;
    key_valid_r && key_r[KEY_TCP_POS] |-> key_r[KEY_TCP_OR_UDP_FLAG_POS] && key_r[KEY_IP_OR_SNAP_FLAG_POS];
  endproperty
  a_tcp: assert property (p_tcp)
    else $error("TCP flag without TCP or UDP flag");

  property p_latency;
    frame_in.valid && ctrl_r[CTRL_EN_BIT] |-> ##2 key_valid_r;
  endproperty
  a_latency: assert property (p_latency)
    else $error("key not produced two cycles after frame");

  property p_half;
    !ctrl_r[CTRL_AUTO_BIT] && $stable(ctrl_r) |=> half_key_type_r == $past(ctrl_r[CTRL_HALF_BIT]);
  endproperty
  a_half: assert property (p_half)
    else $error("half key type does not follow control");

  // The next seven checks below pin a flag or overload each to the descriptor of two cycles back, so a
  // field that is merely consistent with its neighbours still fails if it is stale.
  property p_ip_proto;
    key_valid_r && key_r[KEY_TYPE_FLAG_POS] && !key_r[KEY_TCP_OR_UDP_FLAG_POS] && !key_r[KEY_OAM_POS]
      && ($past(frame_in.is_ipv4, 2) || $past(frame_in.is_ipv6, 2))
      |-> ovl_seen == {8'h00, $past(frame_in.ip_proto, 2)};
  endproperty
  a_ip_proto: assert property (p_ip_proto)
    else $error("IP protocol not in overloaded field");

  property p_overloaded_type_field;
    key_valid_r && key_r[KEY_TYPE_FLAG_POS] && !key_r[KEY_IP_OR_SNAP_FLAG_POS] && !key_r[KEY_OAM_POS]
      |-> ovl_seen == $past(frame_in.type_or_length_flag, 2);
  endproperty
  a_overloaded_type_field: assert property (p_overloaded_type_field)
    else $error("EtherType not in overloaded field");

  property p_oam_encoding;
    key_valid_r && $past(frame_in.type_or_length_flag, 2) == OAM_OVERLOADED_TYPE_FIELD
      |-> key_r[KEY_OAM_POS] && ovl_seen[15:8] == OAM_HI;
  endproperty
  a_oam_encoding: assert property (p_oam_encoding)
    else $error("OAM encoding without OAM flag");

  property p_ipv4;
    key_valid_r |-> key_r[KEY_IPV4_POS] == $past(frame_in.is_ipv4, 2);
  endproperty
  a_ipv4: assert property (p_ipv4)
    else $error("IPv4 flag wrong");

  property p_frag_ofs;
    key_valid_r |-> key_r[KEY_NONFIRST_POS] == ($past(frame_in.is_ipv4, 2)
      && $past(frame_in.frag_ofs, 2) != 13'h0000);
  endproperty
  a_frag_ofs: assert property (p_frag_ofs)
    else $error("non-first fragment flag wrong");

  property p_tcp_or_udp_flag;
    key_valid_r |-> key_r[KEY_TCP_OR_UDP_FLAG_POS] == (($past(frame_in.is_ipv4, 2)
      || $past(frame_in.is_ipv6, 2)) && ($past(frame_in.ip_proto, 2) == PROTO_TCP
      || $past(frame_in.ip_proto, 2) == PROTO_UDP));
  endproperty
  a_tcp_or_udp_flag: assert property (p_tcp_or_udp_flag)
    else $error("TCP or UDP flag wrong");

  property p_tcp_only;
    key_valid_r |-> key_r[KEY_TCP_POS] == (($past(frame_in.is_ipv4, 2)
      || $past(frame_in.is_ipv6, 2)) && $past(frame_in.ip_proto, 2) == PROTO_TCP);
  endproperty
  a_tcp_only: assert property (p_tcp_only)
    else $error("TCP flag wrong");

  property p_key_hold;
    !dec.valid |=> $stable(key_r);
  endproperty
  a_key_hold: assert property (p_key_hold)
    else $error("key changed without a frame");

  property p_no_key;
    !(frame_in.valid && ctrl_r[CTRL_EN_BIT]) |-> ##2 !key_valid_r;
  endproperty
  a_no_key: assert property (p_no_key)
    else $error("key produced without an accepted frame");

  property p_rd_idle;
    !reg_req.rd |=> rd_data_r == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside the read cycle");

  property p_cnt_clear;
    reg_req.wr && reg_req.addr == REG_COUNT && !dec.valid
      |=> frame_cnt_r == CNT_RESET && oam_cnt_r == CNT_RESET;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear)
    else $error("count register not cleared by write");

  c_oam: cover property (key_valid_r && key_r[KEY_OAM_POS]);
  c_tcp: cover property (key_valid_r && key_r[KEY_TCP_POS]);
  c_nonfirst: cover property (key_valid_r && key_r[KEY_NONFIRST_POS]);
  c_ctrl_wr: cover property (reg_req.wr && reg_req.addr == REG_CTRL ##1 reg_req.rd);
  c_auto: cover property (ctrl_r[CTRL_AUTO_BIT] && key_valid_r);

endmodule

//--- logic/dvk_pkg.sv
// Shared constants and carrier types for the double VLAN quad key field builder.
// Assumes one core clock domain shared by the frame parser, this block and the matcher.
package dvk_pkg;

  localparam int KEY_W = 93;
  localparam int KEY_OAM_POS = 23;
  localparam int KEY_TYPE_FLAG_POS = 63;
  localparam int KEY_OVL_POS = 64;
  localparam int OVL_W = 16;
  localparam int KEY_IP_OR_SNAP_FLAG_POS = 80;
  localparam int KEY_IPV4_POS = 81;
  localparam int KEY_FRAG_POS = 82;
  localparam int KEY_NONFIRST_POS = 83;
  localparam int KEY_OPTS_POS = 84;
  localparam int KEY_DSCP_POS = 85;
  localparam int DSCP_W = 6;
  localparam int KEY_TCP_OR_UDP_FLAG_POS = 91;
  localparam int KEY_TCP_POS = 92;
  localparam int UPPER_W = KEY_W - KEY_TYPE_FLAG_POS;

  localparam logic [15:0] TYPE_MIN = 16'h0600;
  localparam logic [15:0] OAM_OVERLOADED_TYPE_FIELD = 16'h8902;
  localparam logic [7:0] OAM_HI = 8'h89;
  localparam logic [3:0] IHL_NO_OPTS = 4'h5;
  localparam logic [7:0] PROTO_TCP = 8'h06;
  localparam logic [7:0] PROTO_UDP = 8'h11;

  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] REG_COUNT = 8'h04;
  localparam logic [REG_AW-1:0] REG_LAST_KEY = 8'h08;
  localparam logic [REG_AW-1:0] REG_FRAG_COUNT = 8'h0C;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_HALF_BIT = 1;
  localparam int CTRL_AUTO_BIT = 2;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h1;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

  typedef struct packed {
    logic valid;
    logic [15:0] type_or_length_flag;
    logic is_snap;
    logic is_ipv4;
    logic is_ipv6;
    logic [7:0] dsap;
    logic [7:0] ssap;
    logic [15:0] pid_hi;
    logic [7:0] ip_proto;
    logic [15:0] dport;
    logic more_frag;
    logic [12:0] frag_ofs;
    logic [3:0] ihl;
    logic [5:0] dscp;
    logic oam_masq;
    logic [6:0] meg_level;
  } frame_desc_t;

  typedef struct packed {
    logic valid;
    logic type_flag;
    logic [OVL_W-1:0] ovl;
    logic oam;
    logic ip_or_snap_flag;
    logic ipv4;
    logic frag;
    logic nonfirst;
    logic opts;
    logic [DSCP_W-1:0] dscp;
    logic tcp_or_udp_flag;
    logic tcp;
  } dec_t;

  typedef struct packed {
    logic valid;
    logic [KEY_W-1:0] key;
  } key_out_t;

  typedef struct packed {
    logic [REG_AW-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

//--- logic/frame_field_decoder.sv
// Frame field decoder: turns one parsed frame descriptor into registered key fields.
// Assumes the parser drives the descriptor on the core clock, one cycle per frame.
`timescale 1ns/100ps
module frame_field_decoder (
  input wire logic core_clk,
  input wire logic rst_b,
  input dvk_pkg::frame_desc_t frame,
  input wire logic en,
  output dvk_pkg::dec_t dec_r
);
  import dvk_pkg::*;

  function automatic logic is_ip(input frame_desc_t f);
    return f.is_ipv4 | f.is_ipv6;
  endfunction

  function automatic logic is_tcp(input frame_desc_t f);
    return is_ip(f) & (f.ip_proto == PROTO_TCP);
  endfunction

  function automatic logic is_l4(input frame_desc_t f);
    return is_tcp(f) | (is_ip(f) & (f.ip_proto == PROTO_UDP));
  endfunction

  logic type_flag;
  logic oam;
  logic [OVL_W-1:0] ovl_nxt;

  assign type_flag = frame.type_or_length_flag >= TYPE_MIN;
  assign oam = frame.type_or_length_flag == OAM_OVERLOADED_TYPE_FIELD;

  // The OAM encoding wins over every other overload because its EtherType is type encoded.
  always_comb begin
    if (oam) begin
      ovl_nxt = {OAM_HI, frame.oam_masq, frame.meg_level};
    end else if (!type_flag) begin
      ovl_nxt = frame.is_snap ? frame.pid_hi : {frame.dsap, frame.ssap};
    end else if (is_l4(frame)) begin
      ovl_nxt = frame.dport;
    end else if (is_ip(frame)) begin
      ovl_nxt = {8'h00, frame.ip_proto};
    end else begin
      ovl_nxt = frame.type_or_length_flag;
    end
  end

  // Options are neither skipped nor parsed, so the port taken for a fragmented or
  // option-bearing frame is whatever sits at the fixed offset and is not to be trusted.
  // The whole descriptor lives in one process because it is one packed variable.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_r <= '0;
    end else begin
      dec_r.valid <= frame.valid & en;
      if (frame.valid & en) begin
        dec_r.type_flag <= type_flag;
        dec_r.ovl <= ovl_nxt;
        dec_r.oam <= oam;
        dec_r.ip_or_snap_flag <= is_ip(frame) | frame.is_snap;
        dec_r.ipv4 <= frame.is_ipv4;
        dec_r.frag <= frame.is_ipv4 & (frame.more_frag | (frame.frag_ofs != 13'h0000));
        dec_r.nonfirst <= frame.is_ipv4 & (frame.frag_ofs != 13'h0000);
        dec_r.opts <= frame.is_ipv4 & (frame.ihl > IHL_NO_OPTS);
        dec_r.dscp <= frame.dscp;
        dec_r.tcp_or_udp_flag <= is_l4(frame);
        dec_r.tcp <= is_tcp(frame);
      end
    end
  end

endmodule

//--- bench/frame_src.sv
// Frame parser model that feeds descriptors to the key field builder.
// Assumes the caller waits for each task to return before calling the next one.
`timescale 1ns/100ps
module frame_src (
  input wire logic core_clk,
  output dvk_pkg::frame_desc_t frame_out
);
  import dvk_pkg::*;

  initial begin
    frame_out = '0;
  end

  // One descriptor per call, so back-to-back calls keep valid high every cycle.
  task automatic send(input frame_desc_t d);
    @(posedge core_clk);
    frame_out <= d;
  endtask

  // Released fields show the inverse, so a stale descriptor cannot match by luck.
  task automatic idle_bus();
    frame_desc_t t;
    @(posedge core_clk);
    t = ~frame_out;
    t.valid = 1'h0;
    frame_out <= t;
  endtask
endmodule

//--- bench/test_dbl_vlan_key_fields.sv
// Self-checking bench for the upper key field builder and its register port.
// Assumes a single core clock and keys that appear two cycles after the descriptor.
`timescale 1ns/100ps
module test_dbl_vlan_key_fields;
  import dvk_pkg::*;
  typedef struct packed {logic [KEY_W-1:0] key; logic [31:0] due;} exp_t;
  typedef struct packed {
    logic [15:0] et; logic [2:0] sv; logic [7:0] pr; logic mf; logic [12:0] ofs;
    logic [3:0] ihl; logic [5:0] dscp; logic [7:0] fl; logic [15:0] ovl; logic oam;
  } row_t;
  logic core_clk;
  logic rst_b;
  frame_desc_t frame_in;
  reg_req_t reg_req;
  key_out_t key_out;
  logic half_key_type;
  logic [31:0] rd_data;
  logic [31:0] cyc = '0;
  logic [KEY_W-1:0] last_key;
  int fail_count;
  int n_tests;
  exp_t exp_q[$];
  row_t rows[11];

  dbl_vlan_key_fields i_dbl_vlan_key_fields (.core_clk, .rst_b, .frame_in, .reg_req,
    .key_out, .half_key_type, .rd_data);
  frame_src i_frame_src (.core_clk, .frame_out(frame_in));

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) cyc <= cyc + 32'h1;

  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t ns got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // A key is due exactly two cycles after its descriptor, and no key comes unasked.
  always @(negedge core_clk) begin
    if (rst_b === 1'h1) begin
      if (exp_q.size() > 0 && exp_q[0].due == cyc) begin
        check(key_out.valid, 1'h1);
        check(key_out.key, exp_q[0].key);
        void'(exp_q.pop_front());
      end else begin
        check(key_out.valid, 1'h0);
      end
    end
  end

  function automatic frame_desc_t mk(input row_t r);
    frame_desc_t d;
    d = '0;
    {d.valid, d.dsap, d.ssap, d.pid_hi} = {1'h1, 8'hAA, 8'h03, 16'h1234};
    {d.dport, d.oam_masq, d.meg_level} = {16'h0050, 1'h1, 7'h05};
    {d.type_or_length_flag, d.is_snap, d.is_ipv4, d.is_ipv6, d.ip_proto} = {r.et, r.sv, r.pr};
    {d.more_frag, d.frag_ofs, d.ihl, d.dscp} = {r.mf, r.ofs, r.ihl, r.dscp};
    return d;
  endfunction

  task automatic run_row(input row_t r);
    exp_t e;
    e.key = '0;
    e.key[92:63] = {r.fl[7:6], r.dscp, r.fl[5:1], r.ovl, r.fl[0]};
    e.key[KEY_OAM_POS] = r.oam;
    i_frame_src.send(mk(r));
    e.due = cyc + 32'h3;
    last_key = e.key;
    exp_q.push_back(e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_req <= {a, d, 1'h1, 1'h0};
    @(posedge core_clk);
    reg_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_req <= {a, 32'h0000_0000, 1'h0, 1'h1};
    @(posedge core_clk);
    reg_req <= '0;
    #1 check(rd_data, exp);
  endtask

  initial begin
    repeat (3000) @(posedge core_clk);
    fail_count++;
    end_sim();
  end

  initial begin
    rst_b = 1'h0;
    reg_req = '0;
    rows[0] = {16'h0040, 3'h0, 8'h00, 1'h0, 13'h0, 4'h5, 6'h01, 8'h00, 16'hAA03, 1'h0};
    rows[1] = {16'h05FF, 3'h4, 8'h00, 1'h0, 13'h0, 4'h5, 6'h02, 8'h02, 16'h1234, 1'h0};
    rows[2] = {16'h0600, 3'h0, 8'h00, 1'h0, 13'h0, 4'h5, 6'h03, 8'h01, 16'h0600, 1'h0};
    rows[3] = {16'h0806, 3'h0, 8'h00, 1'h0, 13'h0, 4'h5, 6'h04, 8'h01, 16'h0806, 1'h0};
    rows[4] = {16'h0800, 3'h2, 8'h06, 1'h0, 13'h0, 4'h5, 6'h05, 8'hC7, 16'h0050, 1'h0};
    rows[5] = {16'h0800, 3'h2, 8'h11, 1'h1, 13'h0, 4'h6, 6'h06, 8'h6F, 16'h0050, 1'h0};
    rows[6] = {16'h0800, 3'h2, 8'h01, 1'h0, 13'h1, 4'h5, 6'h07, 8'h1F, 16'h0001, 1'h0};
    rows[7] = {16'h86DD, 3'h1, 8'h06, 1'h0, 13'h0, 4'h5, 6'h3F, 8'hC3, 16'h0050, 1'h0};
    rows[8] = {16'h86DD, 3'h1, 8'h3A, 1'h0, 13'h0, 4'h5, 6'h08, 8'h03, 16'h003A, 1'h0};
    rows[9] = {16'h86DD, 3'h1, 8'h11, 1'h1, 13'h5, 4'h7, 6'h09, 8'h43, 16'h0050, 1'h0};
    rows[10] = {16'h8902, 3'h0, 8'h00, 1'h0, 13'h0, 4'h5, 6'h0A, 8'h01, 16'h8985, 1'h1};
    repeat (16) @(posedge core_clk);
    rst_b <= 1'h1;
    #1 check({key_out, half_key_type, rd_data}, '0);
    rd(REG_CTRL, 32'h0000_0001);
    // Every row goes out back to back, the hardest pace the parser may keep.
    foreach (rows[i]) run_row(rows[i]);
    i_frame_src.idle_bus();
    repeat (3) @(posedge core_clk);
    rd(REG_COUNT, 32'h0001_000B);
    rd(REG_FRAG_COUNT, 32'h0000_0002);
    rd(REG_LAST_KEY, {2'h0, last_key[92:63]});
    rd(8'h10, 32'h0000_0000);
    wr(REG_COUNT, 32'h0000_0000);
    rd(REG_COUNT, 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_0003);
    @(posedge core_clk);
    #1 check(half_key_type, 1'h1);
    wr(REG_CTRL, 32'h0000_0000);
    @(posedge core_clk);
    #1 check(half_key_type, 1'h0);
    // With the builder disabled the frame leaves no key and no count.
    i_frame_src.send(mk(rows[4]));
    i_frame_src.idle_bus();
    repeat (4) @(posedge core_clk);
    rd(REG_COUNT, 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_0001);
    // A reset while a key is in flight must drop it.
    run_row(rows[5]);
    i_frame_src.idle_bus();
    rst_b <= 1'h0;
    exp_q.delete();
    #1 check({key_out, half_key_type, rd_data}, '0);
    repeat (2) @(posedge core_clk);
    rst_b <= 1'h1;
    rd(REG_CTRL, 32'h0000_0001);
    run_row(rows[10]);
    i_frame_src.idle_bus();
    repeat (4) @(posedge core_clk);
    // Automatic mode: the half key type follows the IPv4 flag of each key.
    wr(REG_CTRL, 32'h0000_0005);
    run_row(rows[4]);
    i_frame_src.idle_bus();
    repeat (2) @(posedge core_clk);
    #1 check(half_key_type, 1'h1);
    run_row(rows[7]);
    i_frame_src.idle_bus();
    repeat (2) @(posedge core_clk);
    #1 check(half_key_type, 1'h0);
    // A clear that meets a counted frame in one cycle leaves that frame counted.
    fork
      begin
        @(posedge core_clk);
        wr(REG_COUNT, 32'h0000_0000);
      end
      begin
        run_row(rows[5]);
        i_frame_src.idle_bus();
      end
    join
    rd(REG_COUNT, 32'h0000_0001);
    rd(REG_FRAG_COUNT, 32'h0000_0001);
    wr(REG_FRAG_COUNT, 32'h0000_0000);
    rd(REG_FRAG_COUNT, 32'h0000_0000);
    end_sim();
  end
endmodule
